// >>> core/ccs_ctrl.sv
// secondary command/status control of the codec port, APB slave
// assumes frame timing logic on the same clock gives the command slot strobe
// and returns read answers as a one-cycle strobe with address and data
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "ccs_consts.svh"
module ccs_ctrl
    import ccs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`CCS_ADDR_W-1:0] i_paddr,
    input wire logic [`CCS_DATA_W-1:0] i_pwdata,
    output logic [`CCS_DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_cmd_slot,
    input wire logic i_status_valid,
    input wire logic [7:0] i_status_addr,
    input wire logic [15:0] i_status_data,
    output logic o_slot_valid,
    output logic [15:0] o_slot_addr_word,
    output logic [15:0] o_slot_data_word,
    output logic o_slot_secondary,
    output logic o_codec_reset_out_n,
    output ccs_mode_t o_mode
);
    logic ack_r, ack_nxt;
    logic [`CCS_DATA_W-1:0] rdata_r, rdata_nxt;
    logic err_r, err_nxt;
    logic [5:0] ctrl_r, ctrl_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [15:0] data_r, data_nxt;
    ccs_state_t state_r, state_nxt;
    logic rst_pin_r, rst_pin_nxt;
    logic [15:0] idx;
    logic hit_addr, hit_ctrl, hit_data, hit_stat, hit_any;
    logic access, wr_en, load;
    ccs_mode_t mode;
    logic secondary;
    logic rd_req;

    // decode; the two low address bits only pick the byte and are ignored
    assign idx = i_paddr[`CCS_ADDR_W-1:2];
    assign hit_addr = (idx == `CCS_IDX_ADDR);
    assign hit_ctrl = (idx == `CCS_IDX_CTRL);
    assign hit_data = (idx == `CCS_IDX_DATA);
    assign hit_stat = (idx == `CCS_IDX_STAT);
    assign hit_any = hit_addr | hit_ctrl | hit_data | hit_stat;
    assign access = i_psel & i_penable;
    // writes land only at the edge where pready is seen high
    assign wr_en = access & ack_r & i_pwrite & hit_any;

    assign mode = ccs_mode_t'(ctrl_r[`CCS_CTRL_MODE_HI:`CCS_CTRL_MODE_LO]);
    assign secondary = (ctrl_r[`CCS_CTRL_SEL_HI:`CCS_CTRL_SEL_LO] != `CCS_SEL_PRIMARY);
    // read flag moves with the mode, else a dedicated-mode read never waits for its answer
    assign rd_req = (mode == CCS_MODE_DED) ? addr_r[`CCS_ADR_RW_DED] : addr_r[`CCS_ADR_RW];

    // one wait state so read data can come straight from a flop
    always_comb begin
        ack_nxt = 1'b0;
        rdata_nxt = rdata_r;
        err_nxt = err_r;
        if (access && !ack_r) begin
            ack_nxt = 1'b1;
            err_nxt = !hit_any;
            rdata_nxt = '0;
            case (1'b1)
                hit_addr: rdata_nxt[7:0] = addr_r;
                hit_ctrl: rdata_nxt[5:0] = ctrl_r;
                hit_data: rdata_nxt[15:0] = data_r;
                hit_stat: begin
                    rdata_nxt[`CCS_STAT_BUSY] = (state_r != CCS_ST_IDLE);
                    rdata_nxt[`CCS_STAT_RDWAIT] = (state_r == CCS_ST_STATUS);
                end
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ack_r <= 1'b0;
            rdata_r <= '0;
            err_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
        end
    end

    assign o_pready = ack_r;
    assign o_prdata = rdata_r;
    assign o_pslverr = ack_r & err_r;

    // control register: reset control, codec select and port mode
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_en && hit_ctrl) begin
            ctrl_nxt = i_pwdata[5:0] & `CCS_CTRL_WMASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl_r <= `CCS_CTRL_RST_VAL;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // sequencer: a loaded byte waits for the next command slot, goes out once,
    // and a read then waits for the codec answer
    always_comb begin
        state_nxt = state_r;
        load = 1'b0;
        case (state_r)
            CCS_ST_IDLE: begin
                if (wr_en && hit_addr && mode != CCS_MODE_I2S) begin
                    state_nxt = CCS_ST_SLOT;
                end
            end
            CCS_ST_SLOT: begin
                if (mode == CCS_MODE_I2S) begin
                    state_nxt = CCS_ST_IDLE;
                end else if (i_cmd_slot) begin
                    load = 1'b1;
                    if (rd_req) begin
                        state_nxt = CCS_ST_STATUS;
                    end else begin
                        state_nxt = CCS_ST_IDLE;
                    end
                end
            end
            CCS_ST_STATUS: begin
                if (i_status_valid || mode == CCS_MODE_I2S) begin
                    state_nxt = CCS_ST_IDLE;
                end
            end
            default: state_nxt = CCS_ST_IDLE;
        endcase
        // a fresh load during a wait restarts the sequence with the new byte
        if (state_r != CCS_ST_IDLE && wr_en && hit_addr && mode != CCS_MODE_I2S) begin
            state_nxt = CCS_ST_SLOT;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_r <= CCS_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // address and data registers; a codec answer wins over a software write
    // in the same cycle so the returned index is never lost
    always_comb begin
        addr_nxt = addr_r;
        data_nxt = data_r;
        if (wr_en && hit_addr) begin
            addr_nxt = i_pwdata[7:0];
        end
        if (wr_en && hit_data) begin
            data_nxt = i_pwdata[15:0];
        end
        if (state_r == CCS_ST_STATUS && i_status_valid) begin
            addr_nxt[`CCS_ADR_IDX_HI:0] = i_status_addr[`CCS_ADR_IDX_HI:0];
            if (mode == CCS_MODE_AC97) begin
                data_nxt = i_status_data;
            end else begin
                data_nxt = {8'h00, i_status_data[7:0]};
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            addr_r <= `CCS_ADR_RST_VAL;
            data_r <= `CCS_DATA_RST_VAL;
        end else begin
            addr_r <= addr_nxt;
            data_r <= data_nxt;
        end
    end

    // reset pin: follows the control bit, parked high in I2S where it has no use
    always_comb begin
        rst_pin_nxt = ctrl_nxt[`CCS_CTRL_RST];
        if (ccs_mode_t'(ctrl_nxt[`CCS_CTRL_MODE_HI:`CCS_CTRL_MODE_LO]) == CCS_MODE_I2S) begin
            rst_pin_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rst_pin_r <= 1'b0;
        end else begin
            rst_pin_r <= rst_pin_nxt;
        end
    end

    assign o_codec_reset_out_n = rst_pin_r;
    assign o_mode = mode;

    // slot words for the frame timing logic
    ccs_slot_fmt u_fmt (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_load(load),
        .i_mode(mode),
        .i_addr(addr_r),
        .i_data(data_r),
        .i_secondary(secondary),
        .o_valid(o_slot_valid),
        .o_addr_word(o_slot_addr_word),
        .o_data_word(o_slot_data_word),
        .o_secondary(o_slot_secondary)
    );
endmodule

// >>> core/ccs_consts.svh
// offsets, field positions, reset values and encodings of the secondary command block
// assumes a single 25 MHz clock and APB access with 32-bit data
//
// Contract
// - a codec select value of 00 sends secondary transactions to the primary codec.
// - the codec reset pin follows the reset control bit, low while the bit is zero.
// - the reset control bit clears at reset, so the codec stays in reset until software sets it.
// - the codec reset pin is not used in the I2S mode.
// - a write sends the whole address byte to the codec in the command slot, in place for the mode.
// - the index field selects the codec register that the pending transaction reaches.
// - on a read the hardware overwrites the index field with the address returned by the codec.
// - all eight bits of the address register are read/write and reset to zero.
// - command data is 16 bits in the AC '97 modes and 8 bits in general and dedicated modes.
// - on a read the status data returned by the codec lands in the command data register.
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

`define CCS_ADDR_W 18
`define CCS_DATA_W 32
// register indices; byte address is four times the index
`define CCS_IDX_ADDR 16'hffdb
`define CCS_IDX_CTRL 16'hffdc
`define CCS_IDX_DATA 16'hffdd
`define CCS_IDX_STAT 16'hffde
// control register fields
`define CCS_CTRL_RST 0
`define CCS_CTRL_SEL_HI 2
`define CCS_CTRL_SEL_LO 1
`define CCS_CTRL_MODE_HI 5
`define CCS_CTRL_MODE_LO 4
`define CCS_CTRL_RST_VAL 6'h00
`define CCS_CTRL_WMASK 6'h37
// address register fields
`define CCS_ADR_RW 7
// in the dedicated codec mode the read flag sits at byte bit 5, slot bit 13
`define CCS_ADR_RW_DED 5
`define CCS_ADR_IDX_HI 6
`define CCS_ADR_RST_VAL 8'h00
`define CCS_DATA_RST_VAL 16'h0000
`define CCS_SEL_PRIMARY 2'h0
// status register fields
`define CCS_STAT_BUSY 0
`define CCS_STAT_RDWAIT 1

`endif

// >>> core/ccs_pkg.sv
// types shared by the secondary command block
// assumes the constants header is compiled alongside
package ccs_pkg;
    // port mode, software selected
    typedef enum logic [1:0] {
        CCS_MODE_AC97,
        CCS_MODE_I2S,
        CCS_MODE_GP,
        CCS_MODE_DED
    } ccs_mode_t;
    // transaction sequencer
    typedef enum logic [1:0] {
        CCS_ST_IDLE,
        CCS_ST_SLOT,
        CCS_ST_STATUS
    } ccs_state_t;
endpackage

// >>> core/ccs_slot_fmt.sv
// builds the command slot words handed to the frame timing logic
// assumes i_load is a one-cycle pulse on the command slot strobe
`timescale 1ns/1ps
`include "ccs_consts.svh"
module ccs_slot_fmt
    import ccs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire ccs_mode_t i_mode,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_data,
    input wire logic i_secondary,
    output logic o_valid,
    output logic [15:0] o_addr_word,
    output logic [15:0] o_data_word,
    output logic o_secondary
);
    logic valid_r, valid_nxt;
    logic sec_r, sec_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [15:0] data_r, data_nxt;

    // address byte sits in the top byte so bit 5 reaches slot bit 13
    always_comb begin
        valid_nxt = i_load;
        addr_nxt = addr_r;
        data_nxt = data_r;
        sec_nxt = sec_r;
        if (i_load) begin
            addr_nxt = {i_addr, 8'h00};
            sec_nxt = i_secondary;
            if (i_mode == CCS_MODE_AC97) begin
                data_nxt = i_data;
            end else begin
                data_nxt = {8'h00, i_data[7:0]};
            end
        end
    end

    // slot words and select are held between slots so the timing logic may shift late; valid is one cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            valid_r <= 1'b0;
            addr_r <= 16'h0000;
            data_r <= 16'h0000;
            sec_r <= 1'b0;
        end else begin
            valid_r <= valid_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            sec_r <= sec_nxt;
        end
    end

    assign o_valid = valid_r;
    assign o_addr_word = addr_r;
    assign o_data_word = data_r;
    assign o_secondary = sec_r;
endmodule

// >>> tb/ccs_ctrl_monitor.sv
// port checker for the secondary command block
// assumes it is bound onto ccs_ctrl, one clock domain
`timescale 1ns/1ps
`include "ccs_consts.svh"
module ccs_ctrl_monitor
    import ccs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`CCS_ADDR_W-1:0] i_paddr,
    input wire logic [`CCS_DATA_W-1:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_cmd_slot,
    input wire logic o_slot_valid,
    input wire logic [15:0] o_slot_addr_word,
    input wire logic [15:0] o_slot_data_word,
    input wire logic o_slot_secondary,
    input wire logic o_codec_reset_out_n,
    input wire ccs_mode_t o_mode
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic wr_done, adr_wr, ctl_wr, sel_nz_r, sel_nz_nxt;
    logic [7:0] adr_r, adr_nxt;
    logic pend_r, pend_nxt;
    // shadow of the last loaded byte and select, for slot comparisons
    always_comb begin
        wr_done = i_psel && i_penable && o_pready && i_pwrite;
        adr_wr = wr_done && i_paddr == {`CCS_IDX_ADDR, 2'b00};
        ctl_wr = wr_done && i_paddr == {`CCS_IDX_CTRL, 2'b00};
        adr_nxt = adr_wr ? i_pwdata[7:0] : adr_r;
        sel_nz_nxt = ctl_wr ? (i_pwdata[2:1] != 2'h0) : sel_nz_r;
        // a loaded byte waits for any later slot; i2s drops it
        pend_nxt = pend_r && !i_cmd_slot && o_mode != CCS_MODE_I2S;
        if (adr_wr && o_mode != CCS_MODE_I2S) begin
            pend_nxt = 1'b1;
        end
    end
    always_ff @(posedge i_clk) begin
        adr_r <= adr_nxt;
        sel_nz_r <= sel_nz_nxt;
        if (!i_rst_n) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
        end
    end
    sequence s_acc1;
        i_psel && i_penable && !o_pready;
    endsequence
    sequence s_pend_slot;
        pend_r && i_cmd_slot && o_mode != CCS_MODE_I2S;
    endsequence
    chk_one_wait: assert property (s_acc1 |=> o_pready)
        else $error("ready missing after one wait");
    chk_err_ready: assert property (o_pslverr |-> o_pready)
        else $error("slave error without ready");
    chk_rst_low: assert property (i_rst_n && !$past(i_rst_n) |-> !o_codec_reset_out_n)
        else $error("codec reset not asserted after reset");
    chk_pin_follow: assert property (ctl_wr && i_pwdata[5:4] != 2'h1
        |-> ##2 o_codec_reset_out_n == $past(i_pwdata[0], 2)) else $error("pin not following");
    chk_i2s_high: assert property (o_mode == CCS_MODE_I2S && $past(o_mode) == CCS_MODE_I2S
        |-> o_codec_reset_out_n) else $error("pin driven in i2s");
    chk_slot_launch: assert property (s_pend_slot |=> o_slot_valid)
        else $error("slot not launched");
    chk_slot_once: assert property (o_slot_valid |-> $past(pend_r))
        else $error("launch without pending byte");
    chk_slot_cause: assert property (o_slot_valid |-> $past(i_cmd_slot) && !$past(o_slot_valid))
        else $error("launch without slot");
    chk_slot_sel: assert property (o_slot_valid |-> o_slot_secondary == sel_nz_r)
        else $error("wrong codec selected");
    chk_addr_word: assert property (o_slot_valid |-> o_slot_addr_word == {adr_r, 8'h00})
        else $error("address word wrong");
    chk_narrow_data: assert property (o_slot_valid && o_mode inside {CCS_MODE_GP, CCS_MODE_DED}
        |-> o_slot_data_word[15:8] == 8'h00) else $error("narrow data high byte set");
    chk_word_hold: assert property (!o_slot_valid |-> $stable(o_slot_addr_word))
        else $error("address word changed");
endmodule
bind ccs_ctrl ccs_ctrl_monitor u_ccs_ctrl_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_cmd_slot(i_cmd_slot),
    .o_slot_valid(o_slot_valid), .o_slot_addr_word(o_slot_addr_word),
    .o_slot_data_word(o_slot_data_word), .o_slot_secondary(o_slot_secondary),
    .o_codec_reset_out_n(o_codec_reset_out_n), .o_mode(o_mode));

// >>> tb/ccs_codec_model.sv
// frame slot source plus primary and secondary codec answering reads
// assumes the block's clock; answers promptly or slowly
`timescale 1ns/1ps
module ccs_codec_model #(
    parameter int PERIOD = 12
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_slow,
    input wire logic i_slot_valid,
    input wire logic [15:0] i_addr_word,
    output logic o_cmd_slot,
    output logic o_status_valid,
    output logic [7:0] o_status_addr,
    output logic [15:0] o_status_data
);
    int cnt, wait_c;
    logic [6:0] idx;
    // status lines toggle outside answers so stale values never look valid
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt <= 0;
            wait_c <= 0;
            o_cmd_slot <= 1'b0;
            o_status_valid <= 1'b0;
            o_status_addr <= 8'h00;
            o_status_data <= 16'h0000;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            o_cmd_slot <= (cnt == PERIOD - 1);
            o_status_valid <= (wait_c == 1);
            o_status_addr <= (wait_c == 1) ? {1'b0, idx ^ 7'h55} : ~o_status_addr;
            o_status_data <= (wait_c == 1) ? {8'ha5, 1'b0, idx} : ~o_status_data;
            if (i_slot_valid && i_addr_word[15]) begin
                idx <= i_addr_word[14:8];
                wait_c <= i_slow ? 9 : 2;
            end else if (wait_c != 0) begin
                wait_c <= wait_c - 1;
            end
        end
    end
endmodule

// >>> tb/ccs_ctrl_tb_top.sv
// self-checking bench for the secondary command block
// assumes the codec model supplies slots and read answers
`timescale 1ns/1ps
`include "ccs_consts.svh"
module ccs_ctrl_tb_top
    import ccs_pkg::*;
;
    localparam logic [17:0] A_ADR = {`CCS_IDX_ADDR, 2'b00};
    localparam logic [17:0] A_CTL = {`CCS_IDX_CTRL, 2'b00};
    localparam logic [17:0] A_DAT = {`CCS_IDX_DATA, 2'b00};
    localparam logic [17:0] A_STT = {`CCS_IDX_STAT, 2'b00};
    logic i_clk, i_rst_n, psel, pen, pwr, pready, perr, err, slow, cs, sv, slv, sec_o, pin_n;
    logic sec;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd, v, lfsr;
    logic [7:0] sa, b;
    logic [15:0] sd, aw_o, dw_o, aw, dw;
    logic [1:0] m;
    ccs_mode_t mode;
    int err_total, num_checks, n;
    ccs_ctrl u_ccs_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(perr), .i_cmd_slot(cs), .i_status_valid(sv),
        .i_status_addr(sa), .i_status_data(sd), .o_slot_valid(slv), .o_slot_addr_word(aw_o),
        .o_slot_data_word(dw_o), .o_slot_secondary(sec_o), .o_codec_reset_out_n(pin_n),
        .o_mode(mode));
    ccs_codec_model u_ccs_codec_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow),
        .i_slot_valid(slv), .i_addr_word(aw_o), .o_cmd_slot(cs), .o_status_valid(sv),
        .o_status_addr(sa), .o_status_data(sd));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    function logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task report_and_stop();
        if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one apb transfer; the slave's wait states are not assumed
    task apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            err_total++;
            report_and_stop();
        end
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // counts launches over more than three slot periods, keeping the first words
    task watch();
        n = 0;
        repeat (40) begin
            @(posedge i_clk);
            if (slv === 1'b1 && n == 0) {sec, aw, dw} = {sec_o, aw_o, dw_o};
            if (slv === 1'b1) n++;
        end
    endtask
    initial begin
        {i_rst_n, psel, pen, pwr, slow, paddr, pwdata} = '0;
        {err_total, num_checks, lfsr} = {32'h0, 32'h0, 32'h96fc};
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        apb(1'b0, A_ADR, 32'h0);
        check("addr reset", rd, 32'h0);
        check("pin reset", pin_n, 32'h0);
        apb(1'b0, 18'h00010, 32'h0);
        check("unmapped err", err, 32'h1);
        for (int i = 0; i < 4; i++) begin
            m = (i == 1) ? 2'h2 : (i == 2) ? 2'h3 : 2'h0;
            v = rnd();
            apb(1'b1, A_CTL, {26'h0, m, 1'b0, i[1:0], 1'b1});
            apb(1'b1, A_DAT, v);
            // dedicated mode keeps its read flag at byte bit 5, cleared for a write
            b = {1'b0, v[22:16]} & ((m == 2'h3) ? 8'hdf : 8'hff);
            apb(1'b1, A_ADR, {24'h0, b});
            watch();
            check("launches", n, 32'h1);
            check("secondary", sec, (i != 0));
            check("addr word", aw, {16'h0, b, 8'h00});
            check("data word", dw, (m == 2'h0) ? v[15:0] : {8'h00, v[7:0]});
            check("pin high", pin_n, 32'h1);
            check("mode", mode, m);
            apb(1'b0, A_CTL, 32'h0);
            check("ctrl read", rd, {26'h0, m, 1'b0, i[1:0], 1'b1});
        end
        for (int s = 0; s < 2; s++) begin
            v = rnd();
            m = s[0] ? 2'h2 : 2'h0;
            slow <= ~s[0];
            apb(1'b1, A_CTL, {26'h0, m, 4'h1});
            apb(1'b1, A_ADR, {24'h0, 1'b1, v[6:0]});
            watch();
            check("read launches", n, 32'h1);
            apb(1'b0, A_ADR, 32'h0);
            check("read index", rd, {24'h0, 1'b1, v[6:0] ^ 7'h55});
            apb(1'b0, A_DAT, 32'h0);
            check("status data", rd, {16'h0, s[0] ? 8'h00 : 8'ha5, 1'b0, v[6:0]});
            apb(1'b0, A_STT, 32'h0);
            check("status idle", rd, 32'h0);
        end
        apb(1'b1, A_CTL, 32'h0);
        repeat (2) @(posedge i_clk);
        check("pin low", pin_n, 32'h0);
        v = rnd();
        apb(1'b1, A_CTL, 32'h10);
        apb(1'b1, A_ADR, {24'h0, v[7:0]});
        watch();
        check("i2s launches", n, 32'h0);
        check("i2s pin", pin_n, 32'h1);
        apb(1'b0, A_ADR, 32'h0);
        check("addr rw", rd, {24'h0, v[7:0]});
        report_and_stop();
    end
endmodule
